// ---- rtl/fsps_pkg.sv ----
// Constants for the flash self-programming sequencer.
// Assumes a single 20 MHz clock and a CPU core issuing store/load ops.
package fsps_pkg;
    // Control register bit positions
    localparam int CTL_ENABLE_BIT = 0;
    localparam int CTL_ERASE_BIT = 1;
    localparam int CTL_WRITE_BIT = 2;
    localparam int CTL_LOCK_BIT = 3;
    localparam int CTL_REEN_BIT = 4;
    localparam int CTL_BUSY_BIT = 6;
    localparam int CTL_IE_BIT = 7;
    // Accepted low five-bit command patterns
    localparam logic [4:0] CMD_LOAD = 5'h01;
    localparam logic [4:0] CMD_ERASE = 5'h03;
    localparam logic [4:0] CMD_WRITE = 5'h05;
    localparam logic [4:0] CMD_LOCK = 5'h09;
    localparam logic [4:0] CMD_REEN = 5'h11;
    localparam logic [7:0] CTL_RESET = 8'h00;
    // Address pointer fields
    localparam int PAGE_MSB = 15;
    localparam int PAGE_LSB = 8;
    localparam int WORD_MSB = 7;
    localparam int WORD_LSB = 1;
    localparam int PAGE_WORDS = 128;
    // Readback selectors
    localparam logic [15:0] RD_FUSE_LOW = 16'h0000;
    localparam logic [15:0] RD_LOCK = 16'h0001;
    localparam logic [15:0] RD_FUSE_EXT = 16'h0002;
    localparam logic [15:0] RD_FUSE_HIGH = 16'h0003;
    localparam int LOCK_MSB = 5;
    localparam int LOCK_LSB = 2;
    localparam logic [5:0] LOCK_RESET = 6'h3F;
    // Timing windows in cycles
    localparam logic [2:0] STORE_WINDOW = 3'h4;
    localparam logic [2:0] LOAD_WINDOW = 3'h3;
    // Flash programming time, least figure
    localparam int PROG_TIME_US = 3700;
    localparam int CLOCK_MHZ = 20;
    localparam int PROG_CYCLES = PROG_TIME_US * CLOCK_MHZ;
    // First region address not in the read-while-write part (page index)
    localparam logic [7:0] NO_READ_WHILE_WRITE_REGION_FIRST_PAGE = 8'hE0;
    typedef enum logic [3:0] {
        FSPS_IDLE = 4'b0001,
        FSPS_ARMED = 4'b0010,
        FSPS_BUSY = 4'b0100,
        FSPS_LOCKING = 4'b1000
    } fsps_state_t;
endpackage : fsps_pkg

// ---- rtl/fsps_sync.sv ----
// Two-flop synchroniser for a level from outside the clock domain.
// Assumes the level is slow compared to the clock.
`timescale 1ns/1ns
module fsps_sync (
    input wire logic i_clock, // System clock
    input wire logic i_reset, // Async reset, high
    input wire logic i_async, // Level to synchronise
    output logic o_sync // Synchronised level
);
    logic stage_reg;
    // ****************************************************
    // Two stages; first stage read only by the second
    // ****************************************************
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            stage_reg <= 1'b0;
            o_sync <= 1'b0;
        end else begin
            stage_reg <= i_async;
            o_sync <= stage_reg;
        end
    end
endmodule : fsps_sync

// ---- rtl/fsps_top.sv ----
// Flash self-programming sequencer: control register, page buffer,
// lock setting and fuse/lock readback.
// Assumes the CPU presents one-cycle write/op strobes on this clock and
// that the flash array latches o_flash_* strobes itself.
`timescale 1ns/1ns
module fsps_top #(
    parameter int PROG_CYCLES_P = fsps_pkg::PROG_CYCLES // Programming duration
) (
    input wire logic i_clock, // 20 MHz system clock
    input wire logic i_reset, // Async reset, high
    input wire logic i_ctl_wr, // Control register write strobe
    input wire logic [7:0] i_ctl_wdata, // Control write data
    input wire logic i_store_op, // Store program memory op pulse
    input wire logic i_load_op, // load_prog_mem_op pulse
    input wire logic [15:0] i_addr_ptr, // address_pointer
    input wire logic [7:0] i_data_low, // Low data register
    input wire logic [7:0] i_data_high, // High data register
    input wire logic i_eeprom_write_busy, // eeprom_write_busy, async
    input wire logic [7:0] i_fuse_low_byte, // fuse_low_byte from array
    input wire logic [7:0] i_fuse_high_byte, // fuse_high_byte from array
    input wire logic [1:0] i_extended_fuse_bits, // extended_fuse_bits
    input wire logic [1:0] i_mem_lock, // mem_lock_2, mem_lock_1
    output logic [7:0] o_ctl_rdata, // self_prog_ctrl read value
    output logic o_readback_valid, // Readback byte replaces flash data
    output logic [7:0] o_readback_data, // Fuse or lock byte
    output logic o_ready_irq, // Ready interrupt request
    output logic o_rww_block, // Reads of READ_WHILE_WRITE_REGION region blocked
    output logic o_cpu_halt, // CPU halted (NO_READ_WHILE_WRITE_REGION programming)
    output logic o_flash_erase, // Page erase start pulse
    output logic o_flash_write, // Page write start pulse
    output logic [7:0] o_flash_page, // Latched page_select
    output logic [5:0] o_boot_lock // boot_lock_12..01, 0 = programmed
);
    import fsps_pkg::*;

    // ****************************************************
    // Declarations
    // ****************************************************
    fsps_state_t state_reg;
    logic [7:0] ctl_reg;
    logic [2:0] win_reg;
    logic [31:0] prog_cnt_reg;
    logic [15:0] buf_mem [PAGE_WORDS];
    logic [PAGE_WORDS-1:0] buf_valid_reg;
    logic ee_busy;
    logic [4:0] cmd;
    logic cmd_ok;
    logic store_go;
    logic load_go;
    logic [6:0] word_idx;
    logic prog_done;

    // ****************************************************
    // Input synchronisation
    // ****************************************************
    fsps_sync u_ee_sync (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_async(i_eeprom_write_busy),
        .o_sync(ee_busy)
    );

    // Decode of a legal command pattern
    function automatic logic fsps_legal(input logic [4:0] c);
        return (c == CMD_LOAD) || (c == CMD_ERASE) || (c == CMD_WRITE)
            || (c == CMD_LOCK) || (c == CMD_REEN);
    endfunction : fsps_legal

    // Page lies in the no-read-while-write region
    function automatic logic fsps_in_no_read_while_write_region(input logic [7:0] page);
        return page >= NO_READ_WHILE_WRITE_REGION_FIRST_PAGE;
    endfunction : fsps_in_no_read_while_write_region

    // Command strobes; EEPROM activity rejects everything
    assign cmd = i_ctl_wdata[4:0];
    assign cmd_ok = i_ctl_wr && fsps_legal(cmd) && !ee_busy && state_reg == FSPS_IDLE;
    assign store_go = i_store_op && state_reg == FSPS_ARMED && !ee_busy;
    assign load_go = i_load_op && state_reg == FSPS_ARMED && !ee_busy
        && ctl_reg[4:0] == CMD_LOCK && win_reg > (STORE_WINDOW - LOAD_WINDOW);
    assign word_idx = i_addr_ptr[WORD_MSB:WORD_LSB];
    assign prog_done = prog_cnt_reg == 32'(PROG_CYCLES_P - 1);

    // ****************************************************
    // Sequencer state
    // ****************************************************
    // Window counts down four clocks; the load window is its first three
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            state_reg <= FSPS_IDLE;
            win_reg <= 3'h0;
            prog_cnt_reg <= 32'h0;
        end else begin
            unique case (state_reg)
                FSPS_IDLE: begin
                    if (cmd_ok) begin
                        state_reg <= FSPS_ARMED;
                        win_reg <= STORE_WINDOW;
                    end
                end
                FSPS_ARMED: begin
                    win_reg <= win_reg - 3'h1;
                    prog_cnt_reg <= 32'h0;
                    if (store_go && (ctl_reg[4:0] == CMD_ERASE || ctl_reg[4:0] == CMD_WRITE)) begin
                        state_reg <= FSPS_BUSY;
                    end else if (store_go && ctl_reg[4:0] == CMD_LOCK) begin
                        state_reg <= FSPS_LOCKING;
                    end else if (store_go || load_go || win_reg == 3'h1 || ee_busy) begin
                        state_reg <= FSPS_IDLE;
                    end
                end
                FSPS_BUSY, FSPS_LOCKING: begin
                    prog_cnt_reg <= prog_cnt_reg + 32'h1;
                    if (prog_done) begin
                        state_reg <= FSPS_IDLE;
                    end
                end
                default: begin
                    state_reg <= FSPS_IDLE;
                end
            endcase
        end
    end

    // ****************************************************
    // Control register
    // ****************************************************
    // Command bits held while armed, and while busy if stored before the last window clock; cleared on completion
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            ctl_reg <= CTL_RESET;
        end else begin
            if (i_ctl_wr) begin
                ctl_reg[CTL_IE_BIT] <= i_ctl_wdata[CTL_IE_BIT];
            end
            if (cmd_ok) begin
                ctl_reg[4:0] <= cmd;
            end else if (state_reg == FSPS_ARMED && (win_reg == 3'h1 || ee_busy || load_go
                || (store_go && ctl_reg[4:0] != CMD_ERASE && ctl_reg[4:0] != CMD_WRITE
                && ctl_reg[4:0] != CMD_LOCK))) begin
                ctl_reg[4:0] <= 5'h00;
            end else if ((state_reg == FSPS_BUSY || state_reg == FSPS_LOCKING) && prog_done) begin
                ctl_reg[4:0] <= 5'h00;
            end
            // Busy flag: set on erase/write start of a page below the no-read-while-write region, cleared by reenable or load
            if (store_go && (ctl_reg[4:0] == CMD_ERASE || ctl_reg[4:0] == CMD_WRITE)
                && !fsps_in_no_read_while_write_region(i_addr_ptr[PAGE_MSB:PAGE_LSB])) begin
                ctl_reg[CTL_BUSY_BIT] <= 1'b1;
            end else if (store_go && (ctl_reg[4:0] == CMD_REEN || ctl_reg[4:0] == CMD_LOAD)) begin
                ctl_reg[CTL_BUSY_BIT] <= 1'b0;
            end
            ctl_reg[5] <= 1'b0;
        end
    end

    // ****************************************************
    // Temporary page buffer
    // ****************************************************
    // Valid bits cleared on completion of a write stored before the last window clock, reenable, reset, EEPROM hit
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            buf_valid_reg <= '0;
        end else if (state_reg == FSPS_BUSY && prog_done && ctl_reg[4:0] == CMD_WRITE) begin
            buf_valid_reg <= '0;
        end else if (store_go && ctl_reg[4:0] == CMD_REEN) begin
            buf_valid_reg <= '0;
        end else if (ee_busy && |buf_valid_reg) begin
            buf_valid_reg <= '0;
        end else if (store_go && ctl_reg[4:0] == CMD_LOAD) begin
            buf_valid_reg[word_idx] <= 1'b1;
        end
    end

    // Buffer words; no reset needed since valid bits gate use
    always_ff @(posedge i_clock) begin
        if (store_go && ctl_reg[4:0] == CMD_LOAD) begin
            buf_mem[word_idx] <= {i_data_high, i_data_low};
        end
    end

    // ****************************************************
    // Flash strobes and page latch
    // ****************************************************
    // Page latched at the store so the pointer is free afterwards
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            o_flash_erase <= 1'b0;
            o_flash_write <= 1'b0;
            o_flash_page <= 8'h00;
        end else begin
            o_flash_erase <= store_go && ctl_reg[4:0] == CMD_ERASE;
            o_flash_write <= store_go && ctl_reg[4:0] == CMD_WRITE;
            if (store_go && (ctl_reg[4:0] == CMD_ERASE || ctl_reg[4:0] == CMD_WRITE)) begin
                o_flash_page <= i_addr_ptr[PAGE_MSB:PAGE_LSB];
            end
        end
    end

    // ****************************************************
    // Boot lock bits
    // ****************************************************
    // Locks can only be programmed (1 to 0) here; erase is not reachable
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            o_boot_lock <= LOCK_RESET;
        end else if (store_go && ctl_reg[4:0] == CMD_LOCK) begin
            o_boot_lock[3:0] <= o_boot_lock[3:0] & i_data_low[LOCK_MSB:LOCK_LSB];
        end
    end

    // ****************************************************
    // Readback
    // ****************************************************
    // Pointer picks the byte; bits are returned as stored, 0 = programmed
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            o_readback_valid <= 1'b0;
            o_readback_data <= 8'h00;
        end else begin
            o_readback_valid <= load_go;
            if (load_go) begin
                unique case (i_addr_ptr)
                    RD_LOCK: o_readback_data <= {2'b11, o_boot_lock[3:0], i_mem_lock};
                    RD_FUSE_LOW: o_readback_data <= i_fuse_low_byte;
                    RD_FUSE_HIGH: o_readback_data <= i_fuse_high_byte;
                    RD_FUSE_EXT: o_readback_data <= {6'h3F, i_extended_fuse_bits};
                    default: o_readback_data <= 8'hFF;
                endcase
            end
        end
    end

    // ****************************************************
    // Status outputs
    // ****************************************************
    // Lock programming never blocks or halts, only page operations do
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            o_rww_block <= 1'b0;
            o_cpu_halt <= 1'b0;
            o_ready_irq <= 1'b0;
            o_ctl_rdata <= CTL_RESET;
        end else begin
            o_rww_block <= ctl_reg[CTL_BUSY_BIT];
            o_cpu_halt <= state_reg == FSPS_BUSY && fsps_in_no_read_while_write_region(o_flash_page);
            o_ready_irq <= ctl_reg[CTL_IE_BIT] && ctl_reg[CTL_ENABLE_BIT] == 1'b0;
            o_ctl_rdata <= ctl_reg;
        end
    end
endmodule : fsps_top

// ---- bench/fsps_cpu_model.sv ----
// CPU core model: a control write, then an optional store or load op.
// Assumes it shares the sequencer clock; the caller keeps ops apart.
`timescale 1ns/1ns
module fsps_cpu_model (
    input wire logic i_clock, // System clock
    output logic o_ctl_wr, // Control write strobe
    output logic [7:0] o_ctl_wdata, // Control data
    output logic o_store_op, // Store op pulse
    output logic o_load_op, // Load op pulse
    output logic [15:0] o_addr_ptr, // address_pointer
    output logic [7:0] o_data_low, // Low data
    output logic [7:0] o_data_high // High data
);
    // ************************************************
    // Timed command sequence
    // ************************************************
    initial begin
        o_ctl_wr = 1'b0;
        o_ctl_wdata = 8'h00;
        o_store_op = 1'b0;
        o_load_op = 1'b0;
        o_addr_ptr = 16'h0000;
        o_data_low = 8'hFF;
        o_data_high = 8'hFF;
    end
    // Kind 1 stores, 2 loads, 0 lets the window lapse; gap adds idle edges
    task automatic run(input logic [7:0] cmd, input logic [15:0] ptr, input logic [7:0] dlow,
                       input int kind, input int gap);
        @(posedge i_clock);
        #1;
        o_ctl_wr = 1'b1;
        o_ctl_wdata = cmd;
        o_addr_ptr = ptr;
        o_data_low = dlow;
        o_data_high = 8'($urandom);
        @(posedge i_clock);
        #1;
        o_ctl_wr = 1'b0;
        repeat (gap) begin
            @(posedge i_clock);
            #1;
        end
        o_store_op = (kind == 1);
        o_load_op = (kind == 2);
        @(posedge i_clock);
        #1;
        o_store_op = 1'b0;
        o_load_op = 1'b0;
    endtask : run
endmodule : fsps_cpu_model

// ---- bench/fsps_top_sva.sv ----
// Checker for the sequencer's ports.
// Assumes a short programming count (at least 8 cycles) in simulation.
`timescale 1ns/1ns
module fsps_chk #(
    parameter int PROG_CYCLES_P = 8 // Programming duration
) (
    input wire logic i_clock, // System clock
    input wire logic i_reset, // Async reset
    input wire logic i_load_op, // Load op
    input wire logic i_store_op, // Store op
    input wire logic [7:0] o_ctl_rdata, // Control readback
    input wire logic o_readback_valid, // Readback pulse
    input wire logic o_ready_irq, // Ready interrupt
    input wire logic o_rww_block, // READ_WHILE_WRITE_REGION blocked
    input wire logic o_cpu_halt, // CPU halt
    input wire logic o_flash_erase, // Erase pulse
    input wire logic o_flash_write, // Write pulse
    input wire logic [7:0] o_flash_page, // Latched page
    input wire logic [5:0] o_boot_lock // Boot locks
);
    // ************************************************
    // Port relations
    // ************************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);
    rb_cause_a: assert property (o_readback_valid |-> $past(i_load_op)) else $error("readback without load");
    rb_close_a: assert property (o_readback_valid |=> !o_ctl_rdata[0] && !o_ctl_rdata[3])
        else $error("window still open after readback");
    irq_level_a: assert property ((o_ctl_rdata[7] && !o_ctl_rdata[0]) [*3] |-> o_ready_irq)
        else $error("ready interrupt missing");
    busy_flag_a: assert property ($rose(o_rww_block) |-> ##[0:2] o_ctl_rdata[6]) else $error("busy flag not shown");
    write_cause_a: assert property (o_flash_write |-> $past(i_store_op)) else $error("write without store");
    rww_write_a: assert property (o_flash_write && o_flash_page < 8'hE0 |-> ##[0:1] o_rww_block && !o_cpu_halt)
        else $error("rww write not blocking");
    halt_no_read_while_write_region_a: assert property (o_cpu_halt |-> o_flash_page >= 8'hE0 && o_ctl_rdata[0] && (o_ctl_rdata[1] || o_ctl_rdata[2]))
        else $error("halt outside no_read_while_write_region page op");
    enable_held_a: assert property (o_flash_write || o_flash_erase |-> ##1 o_ctl_rdata[0] [*4])
        else $error("enable dropped during page op");
    lock_fixed_a: assert property (o_boot_lock[5:4] == 2'b11) else $error("upper lock bits changed");
    lock_clear_a: assert property ((o_boot_lock & ~$past(o_boot_lock)) == 6'h00)
        else $error("lock bit returned to one");
endmodule : fsps_chk
bind fsps_top fsps_chk #(.PROG_CYCLES_P(PROG_CYCLES_P)) u_chk (.i_clock(i_clock), .i_reset(i_reset),
    .i_load_op(i_load_op), .i_store_op(i_store_op), .o_ctl_rdata(o_ctl_rdata),
    .o_readback_valid(o_readback_valid), .o_ready_irq(o_ready_irq), .o_rww_block(o_rww_block),
    .o_cpu_halt(o_cpu_halt), .o_flash_erase(o_flash_erase), .o_flash_write(o_flash_write),
    .o_flash_page(o_flash_page), .o_boot_lock(o_boot_lock));

// ---- bench/tb_top.sv ----
// Self-checking bench for the sequencer: readbacks, locks, page ops.
// Assumes the CPU model drives all op inputs 1 ns after the edge.
`timescale 1ns/1ns
module tb_top;
    import fsps_pkg::*;
    // ************************************************
    // Signals, design and partner
    // ************************************************
    logic i_clock = 1'b0, i_reset = 1'b1, wr, st, ld, ee = 1'b0, rbv, irq, rwwb, halt, ers, wrp;
    logic [7:0] wd, dl, dh, fl = 8'h00, fh = 8'h00, rd, rbd, pg, e, m;
    logic [15:0] ptr;
    logic [1:0] fx = 2'h0, ml = 2'h0;
    logic [5:0] bl;
    logic [3:0] bl_exp = 4'hF, v;
    logic [7:0] exp_q[$], msk_q[$], page_q[$];
    int miscompares = 0, checks_done = 0;
    always #25 i_clock = ~i_clock;
    fsps_cpu_model cpu (.i_clock(i_clock), .o_ctl_wr(wr), .o_ctl_wdata(wd), .o_store_op(st), .o_load_op(ld),
        .o_addr_ptr(ptr), .o_data_low(dl), .o_data_high(dh));
    fsps_top #(.PROG_CYCLES_P(8)) dut (.i_clock(i_clock), .i_reset(i_reset), .i_ctl_wr(wr), .i_ctl_wdata(wd),
        .i_store_op(st), .i_load_op(ld), .i_addr_ptr(ptr), .i_data_low(dl), .i_data_high(dh),
        .i_eeprom_write_busy(ee), .i_fuse_low_byte(fl), .i_fuse_high_byte(fh), .i_extended_fuse_bits(fx),
        .i_mem_lock(ml), .o_ctl_rdata(rd), .o_readback_valid(rbv), .o_readback_data(rbd), .o_ready_irq(irq),
        .o_rww_block(rwwb), .o_cpu_halt(halt), .o_flash_erase(ers), .o_flash_write(wrp), .o_flash_page(pg),
        .o_boot_lock(bl));
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic conclude();
        $display("miscompares %0d checks_done %0d", miscompares, checks_done);
        if (miscompares == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : conclude
    // Waits for the enable bit to drop, bounded so a stuck op ends the run
    task automatic wait_idle();
        int n;
        n = 0;
        @(posedge i_clock);
        while (rd[0] !== 1'b0 && n < 100) begin
            @(posedge i_clock);
            n++;
        end
        if (n == 100) chk("idle wait", 8'h00, 8'h01);
        if (n == 100) conclude();
        repeat (2) @(posedge i_clock);
        #2;
    endtask : wait_idle
    task automatic rd_byte(input int k);
        e = (k == 0) ? fl : (k == 1) ? {2'b11, bl_exp, ml} : (k == 2) ? {6'h00, fx} : fh;
        exp_q.push_back(e);
        msk_q.push_back((k == 1) ? 8'h7F : (k == 2) ? 8'h03 : 8'hFF);
        cpu.run(8'h09, 16'(k), 8'hFF, 2, k % 2);
        wait_idle();
    endtask : rd_byte
    // Results are matched at the edge after the pulse; a pulse nobody expected is a mismatch
    // Own locals: the scenario process also writes e while queueing notes
    always @(posedge i_clock) begin : result_watch
        logic [7:0] rm;
        logic [7:0] re;
        rm = 8'hFF;
        re = 8'h00;
        if (rbv === 1'b1) begin
            rm = (msk_q.size() > 0) ? msk_q.pop_front() : 8'hFF;
            re = (exp_q.size() > 0) ? exp_q.pop_front() : ~rbd;
            chk("readback", re & rm, rbd & rm);
        end
        if (wrp === 1'b1 || ers === 1'b1) chk("page", (page_q.size() > 0) ? page_q.pop_front() : ~pg, pg);
    end
    // ************************************************
    // Scenarios
    // ************************************************
    initial begin
        void'($urandom(32'h9FE8519E));
        {fl, fh, fx, ml} = 20'($urandom);
        repeat (6) @(posedge i_clock);
        #1 i_reset = 1'b0;
        chk("reset", 8'h3F, {2'b00, bl});
        chk("reset control", 8'h00, rd);
        for (int k = 0; k < 4; k++) rd_byte(k);
        v = 4'($urandom);
        bl_exp = bl_exp & v;
        cpu.run(8'h09, 16'h0001, {2'b11, v, 2'b11}, 1, 2);
        chk("lock halt", 8'h00, {6'h00, halt, rwwb});
        wait_idle();
        chk("boot locks", {4'h3, bl_exp}, {2'b00, bl});
        rd_byte(1);
        cpu.run(8'h09, 16'h0001, 8'hFF, 0, 0);
        repeat (6) @(posedge i_clock);
        chk("window lapse", 8'h00, {3'h0, rd[4:0]});
        cpu.run(8'h09, 16'h0001, 8'hFF, 2, 3);
        for (int i = 0; i < 4; i++) begin
            cpu.run(i == 0 ? 8'h07 : i == 1 ? 8'h1F : i == 2 ? 8'h0B : 8'h15, 16'h0001, 8'h00, 1, 0);
            repeat (3) @(posedge i_clock);
            chk("illegal pattern", 8'h00, {3'h0, rd[4:0]});
        end
        ee = 1'b1;
        repeat (3) @(posedge i_clock);
        cpu.run(8'h09, 16'h0000, 8'hFF, 2, 0);
        cpu.run(8'h05, 16'h1000, 8'h00, 1, 0);
        repeat (3) @(posedge i_clock);
        chk("eeprom refuse", 8'h00, {3'h0, rd[4:0]});
        ee = 1'b0;
        repeat (3) @(posedge i_clock);
        e = 8'($urandom) % 8'hE0;
        cpu.run(8'h01, {8'h00, 7'($urandom), 1'b0}, 8'($urandom), 1, 0);
        wait_idle();
        page_q.push_back(e);
        cpu.run(8'h83, {e, 8'h00}, 8'h00, 1, 1);
        wait_idle();
        page_q.push_back(e);
        cpu.run(8'h85, {e, 8'h00}, 8'h00, 1, 2);
        repeat (3) @(posedge i_clock);
        chk("rww write", 8'h42, {1'b0, rd[6], 4'h0, rwwb, irq});
        wait_idle();
        chk("ready irq", 8'h03, {6'h00, rwwb, irq});
        cpu.run(8'h91, 16'h0000, 8'h00, 1, 0);
        wait_idle();
        chk("reenable", 8'h00, {rd[6], 6'h00, rwwb});
        e = 8'hE0 | 8'($urandom);
        page_q.push_back(e);
        cpu.run(8'h05, {e, 8'h00}, 8'h00, 1, 0);
        repeat (3) @(posedge i_clock);
        chk("no_read_while_write_region halt", 8'h02, {6'h00, halt, rwwb});
        wait_idle();
        chk("halt end", 8'h00, {7'h00, halt});
        chk("leftover", 8'h00, 8'(exp_q.size() + page_q.size()));
        conclude();
    end
endmodule : tb_top
